// ===== tcc_pkg.sv
// Package of constants for the 16-bit timer capture and flip-flop inversion block
package tcc_pkg;
   // ==========================================================
   // Capture mode field encodings
   localparam logic [1:0] CAP_OFF      = 2'h0;
   localparam logic [1:0] CAP_BOTH_IN  = 2'h1;
   localparam logic [1:0] CAP_WIDTH    = 2'h2;
   localparam logic [1:0] CAP_COMPANION = 2'h3;
   // ==========================================================
   // Widths, reset values and count increment
   localparam int          CNT_W        = 16;
   localparam logic [15:0] CNT_RESET    = 16'h0000;
   localparam logic [15:0] CNT_ONE      = 16'h0001;
   localparam logic [1:0]  SYNC_RESET   = 2'h0;
endpackage

// ===== tcc_timer16_capture.sv
// Capture, compare match and output flip-flop logic of the 16-bit up-counting timer
`timescale 1ns/1ps
module tcc_timer16_capture (
   input  wire logic        mclk,
   input  wire logic        arst_n,
   input  wire logic        run,
   input  wire logic        count_ext,
   input  wire logic        int_tick,
   input  wire logic [1:0]  capture_mode_field,
   input  wire logic        clear_on_match_b,
   input  wire logic        inv_on_capture,
   input  wire logic        inv_on_match_a,
   input  wire logic        inv_on_match_b,
   input  wire logic        flipflop_clear,
   input  wire logic [15:0] compare_reg_a,
   input  wire logic [15:0] compare_reg_b,
   input  wire logic        trigger_input_a,
   input  wire logic        trigger_input_b,
   input  wire logic        companion_timer_flipflop,
   output logic [15:0]      up_counter,
   output logic [15:0]      capture_reg_a,
   output logic [15:0]      capture_reg_b,
   output logic             flipflop_output_pin,
   output logic             pin_interrupt_a,
   output logic             pin_interrupt_b,
   output logic             compare_a_match_interrupt,
   output logic             compare_b_match_interrupt
);
   // ==========================================================
   // State
   // All registers of the block except the reset synchroniser live in this one record
   typedef struct packed {
      logic [1:0]  sync_a;
      logic [1:0]  sync_b;
      logic [1:0]  sync_c;
      logic        last_a;
      logic        last_b;
      logic        last_c;
      logic [15:0] cnt;
      logic [15:0] cap_a;
      logic [15:0] cap_b;
      logic        ff;
      logic        irq_a;
      logic        irq_b;
      logic        m_a;
      logic        m_b;
      logic        irq_ma;
      logic        irq_mb;
   } tcc_state_t;

   tcc_state_t st;
   tcc_state_t next_st;
   logic [1:0] rst_sync;
   logic       rst_n;

   // ==========================================================
   // Helpers
   // Edge of a synchronised line against its copy one clock older
   function automatic logic tcc_rise(input logic now_lvl,
                                     input logic old_lvl);
      return now_lvl & ~old_lvl;
   endfunction

   function automatic logic tcc_fall(input logic now_lvl,
                                     input logic old_lvl);
      return ~now_lvl & old_lvl;
   endfunction

   // Arrival already reported while the count stands still on the value;
   // forgotten once the counter moves or the compare value moves away,
   // so a rewritten compare value can match again
   function automatic logic tcc_seen(input logic hit,
                                     input logic tick);
      return hit & ~tick;
   endfunction

   // ==========================================================
   // Reset release
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync <= tcc_pkg::SYNC_RESET;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // ==========================================================
   // Next state
   always_comb begin
      logic a_rise;
      logic a_fall;
      logic b_rise;
      logic c_rise;
      logic c_fall;
      logic tick;
      logic hit_a;
      logic hit_b;
      logic take_a;
      logic take_b;
      a_rise = 1'b0;
      a_fall = 1'b0;
      b_rise = 1'b0;
      c_rise = 1'b0;
      c_fall = 1'b0;
      tick   = 1'b0;
      hit_a  = 1'b0;
      hit_b  = 1'b0;
      take_a = 1'b0;
      take_b = 1'b0;
      next_st = st;
      next_st.sync_a = {st.sync_a[0], trigger_input_a};
      next_st.sync_b = {st.sync_b[0], trigger_input_b};
      next_st.sync_c = {st.sync_c[0], companion_timer_flipflop};
      next_st.last_a = st.sync_a[1];
      next_st.last_b = st.sync_b[1];
      next_st.last_c = st.sync_c[1];
      // Edges are judged on the second synchroniser stage only
      a_rise = tcc_rise(st.sync_a[1], st.last_a);
      a_fall = tcc_fall(st.sync_a[1], st.last_a);
      b_rise = tcc_rise(st.sync_b[1], st.last_b);
      c_rise = tcc_rise(st.sync_c[1], st.last_c);
      c_fall = tcc_fall(st.sync_c[1], st.last_c);
      // Event counting uses trigger A rising edges as the clock
      tick  = run & (count_ext ? a_rise : int_tick);
      hit_a = run & (st.cnt == compare_reg_a);
      hit_b = run & (st.cnt == compare_reg_b);
      // Match events fire once per arrival at the value; with a slow
      // external count the counter may sit on the value many clocks
      next_st.m_a = tcc_seen(hit_a, tick);
      next_st.m_b = tcc_seen(hit_b, tick);
      next_st.irq_ma = hit_a & ~st.m_a;
      next_st.irq_mb = hit_b & ~st.m_b;
      // Counting goes on whatever the capture logic does
      if (tick) begin
         if (clear_on_match_b && hit_b) begin
            next_st.cnt = tcc_pkg::CNT_RESET;
         end else begin
            next_st.cnt = st.cnt + tcc_pkg::CNT_ONE;
         end
      end
      unique case (capture_mode_field)
         tcc_pkg::CAP_OFF: begin
            take_a = 1'b0;
            take_b = 1'b0;
         end
         tcc_pkg::CAP_BOTH_IN: begin
            take_a = a_rise;
            take_b = b_rise;
         end
         tcc_pkg::CAP_WIDTH: begin
            take_a = a_rise;
            take_b = a_fall;
         end
         tcc_pkg::CAP_COMPANION: begin
            take_a = c_rise;
            take_b = c_fall;
         end
      endcase
      // Snapshot held until overwritten
      if (take_a) begin
         next_st.cap_a = st.cnt;
      end
      if (take_b) begin
         next_st.cap_b = st.cnt;
      end
      // Width mode moves interrupt A to the end of the high phase,
      // so software reads both captures of one pulse together
      if (capture_mode_field == tcc_pkg::CAP_WIDTH) begin
         next_st.irq_a = a_fall;
      end else begin
         next_st.irq_a = a_rise;
      end
      next_st.irq_b = b_rise;
      // Simultaneous toggle sources cancel in pairs, as independent inversions would
      if (flipflop_clear) begin
         next_st.ff = 1'b0;
      end else begin
         next_st.ff = st.ff
                      ^ (inv_on_capture & take_a)
                      ^ (inv_on_match_a & hit_a & ~st.m_a)
                      ^ (inv_on_match_b & hit_b & ~st.m_b);
      end
   end

   // ==========================================================
   // Registers
   // Reset clears counter, captures, flip-flop and all pulses
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Outputs
   // Every output is a register bit; interrupts are one-clock pulses
   assign up_counter                = st.cnt;
   assign capture_reg_a             = st.cap_a;
   assign capture_reg_b             = st.cap_b;
   assign flipflop_output_pin       = st.ff;
   assign pin_interrupt_a           = st.irq_a;
   assign pin_interrupt_b           = st.irq_b;
   // Match pulses come whether or not the flip-flop is set to toggle
   assign compare_a_match_interrupt = st.irq_ma;
   assign compare_b_match_interrupt = st.irq_mb;

   // ==========================================================
   // Usage limits
   // A trigger pulse shorter than one clock may be lost in
   // the synchroniser; each edge reaches the captures three clocks late.
   // Captures read the count before that edge's own increment.
   // A compare value equal to the count at reset release also raises
   // its match pulse once, as soon as run is high, before any count tick.
   // Two toggle sources in one clock cancel, as two inversions would.
endmodule

// ===== tcc_timer16_capture_assertions.sv
// Checker of capture, interrupt and flip-flop timing
`timescale 1ns/1ps
module tcc_timer16_capture_chk (
   input wire logic        mclk,
   input wire logic        arst_n,
   input wire logic        run,
   input wire logic [15:0] compare_reg_a,
   input wire logic        compare_a_match_interrupt,
   input wire logic        compare_b_match_interrupt,
   input wire logic [1:0]  capture_mode_field,
   input wire logic        inv_on_capture,
   input wire logic        inv_on_match_a,
   input wire logic        inv_on_match_b,
   input wire logic        flipflop_clear,
   input wire logic [15:0] compare_reg_b,
   input wire logic        trigger_input_a,
   input wire logic        trigger_input_b,
   input wire logic        companion_timer_flipflop,
   input wire logic [15:0] up_counter,
   input wire logic [15:0] capture_reg_a,
   input wire logic [15:0] capture_reg_b,
   input wire logic        flipflop_output_pin,
   input wire logic        pin_interrupt_a,
   input wire logic        pin_interrupt_b
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   rise_int_a_a: assert property (capture_mode_field != 2'h2 && $rose(trigger_input_a) |-> ##[1:4] pin_interrupt_a)
      else $error("pin interrupt a missing after rise");
   fall_int_a_a: assert property (capture_mode_field == 2'h2 && $fell(trigger_input_a) |-> ##[1:4] pin_interrupt_a)
      else $error("pin interrupt a missing after fall");
   rise_int_b_a: assert property (capture_mode_field == 2'h1 && $rose(trigger_input_b) |-> ##[1:4] pin_interrupt_b)
      else $error("pin interrupt b missing");
   width_cap_a: assert property (capture_mode_field == 2'h2 && $fell(trigger_input_a) |-> ##[1:4] $changed(capture_reg_b))
      else $error("no capture b on falling trigger");
   comp_cap_a: assert property (capture_mode_field == 2'h3 && $rose(companion_timer_flipflop) |-> ##[1:4] $changed(capture_reg_a))
      else $error("no capture a on companion rise");
   snap_age_a: assert property ($changed(capture_reg_a) |-> (up_counter - capture_reg_a) < 16'h0008)
      else $error("capture a is not a recent count");
   cap_toggle_a: assert property (inv_on_capture && $changed(capture_reg_a) |-> ##[0:2] $changed(flipflop_output_pin))
      else $error("no toggle on capture");
   quiet_pin_a: assert property ((!inv_on_capture && !inv_on_match_a && !inv_on_match_b && !flipflop_clear) [*4] |-> $stable(flipflop_output_pin))
      else $error("flip-flop moved while disabled");
   match_b_a: assert property (inv_on_match_b && $rose(up_counter == compare_reg_b) |-> ##[0:3] $changed(flipflop_output_pin))
      else $error("no toggle on match b");
   match_a_int_a: assert property (run && $rose(up_counter == compare_reg_a) |-> ##1 compare_a_match_interrupt)
      else $error("no match a pulse");
   match_b_int_a: assert property (run && $rose(up_counter == compare_reg_b) |-> ##1 compare_b_match_interrupt)
      else $error("no match b pulse");
endmodule
bind tcc_timer16_capture tcc_timer16_capture_chk tcc_timer16_capture_chk_inst (.*);

// ===== tcc_pin_model.sv
// Model of the external trigger pins and companion flip-flop
`timescale 1ns/1ps
module tcc_pin_model (
   input  wire logic mclk,
   output logic      trigger_input_a,
   output logic      trigger_input_b,
   output logic      companion_timer_flipflop
);
   initial {trigger_input_a, trigger_input_b, companion_timer_flipflop} = 3'h0;
   // Change a line just after an edge, then hold it
   task automatic drive(input int sel, input logic lvl, input int hold);
      @(posedge mclk);
      case (sel)
         0: trigger_input_a <= lvl;
         1: trigger_input_b <= lvl;
         default: companion_timer_flipflop <= lvl;
      endcase
      repeat (hold) @(posedge mclk);
   endtask
endmodule

// ===== tb_tcc_timer16_capture.sv
// Self-checking bench of the capture and flip-flop block
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; $display("FAIL %0t %h %h", $time, a, b); end end
module tb_tcc_timer16_capture;
   logic mclk = 1'b0, arst_n = 1'b0, run = 1'b1, count_ext = 1'b0, int_tick = 1'b1, clear_on_match_b = 1'b0;
   logic inv_on_capture = 1'b0, inv_on_match_a = 1'b0, inv_on_match_b = 1'b0, flipflop_clear = 1'b0, start;
   logic [1:0]  capture_mode_field = 2'h0;
   logic [15:0] compare_reg_a = 16'h0000, compare_reg_b = 16'h0000, up_counter, capture_reg_a, capture_reg_b;
   logic        trigger_input_a, trigger_input_b, companion_timer_flipflop, flipflop_output_pin;
   logic        pin_interrupt_a, pin_interrupt_b, compare_a_match_interrupt, compare_b_match_interrupt;
   int          errors = 0, compares = 0;
   always #4 mclk = ~mclk;
   tcc_timer16_capture tcc_timer16_capture_inst (.*);
   tcc_pin_model tcc_pin_model_inst (.*);
   task automatic end_of_test();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic t_diff();
      @(posedge mclk) capture_mode_field <= tcc_pkg::CAP_BOTH_IN;
      tcc_pin_model_inst.drive(0, 1'b1, 9);
      tcc_pin_model_inst.drive(1, 1'b1, 9);
      tcc_pin_model_inst.drive(0, 1'b0, 0);
      tcc_pin_model_inst.drive(1, 1'b0, 5);
      `CHK(capture_reg_b - capture_reg_a, 16'h000A)
   endtask
   task automatic t_width();
      @(posedge mclk) capture_mode_field <= tcc_pkg::CAP_WIDTH;
      tcc_pin_model_inst.drive(0, 1'b1, 6);
      tcc_pin_model_inst.drive(0, 1'b0, 5);
      `CHK(capture_reg_b - capture_reg_a, 16'h0007)
   endtask
   task automatic t_comp();
      @(posedge mclk) capture_mode_field <= tcc_pkg::CAP_COMPANION;
      tcc_pin_model_inst.drive(2, 1'b1, 11);
      tcc_pin_model_inst.drive(2, 1'b0, 5);
      `CHK(capture_reg_b - capture_reg_a, 16'h000C)
   endtask
   task automatic t_freq();
      @(posedge mclk) count_ext <= 1'b1;
      tcc_pin_model_inst.drive(2, 1'b1, 3);
      repeat (5) begin
         tcc_pin_model_inst.drive(0, 1'b1, 2);
         tcc_pin_model_inst.drive(0, 1'b0, 2);
      end
      tcc_pin_model_inst.drive(2, 1'b0, 8);
      `CHK(capture_reg_b - capture_reg_a, 16'h0005)
      count_ext <= 1'b0;
   endtask
   task automatic t_shot();
      int i;
      start = flipflop_output_pin;
      @(posedge mclk) capture_mode_field <= tcc_pkg::CAP_BOTH_IN;
      inv_on_capture <= 1'b1;
      tcc_pin_model_inst.drive(0, 1'b1, 6);
      `CHK(flipflop_output_pin, ~start)
      // Software reaction: arm both matches after the capture
      compare_reg_a <= capture_reg_a + 16'h000A;
      compare_reg_b <= capture_reg_a + 16'h0014;
      {inv_on_capture, inv_on_match_a, inv_on_match_b} <= 3'h3;
      for (i = 0; i < 40 && compare_b_match_interrupt !== 1'b1; i++) @(posedge mclk);
      if (i == 40) begin errors++; end_of_test(); end
      {inv_on_match_a, inv_on_match_b} <= 2'h0;
      tcc_pin_model_inst.drive(0, 1'b0, 4);
      `CHK(flipflop_output_pin, ~start)
   endtask
   initial begin
      repeat (16) @(posedge mclk);
      arst_n <= 1'b1;
      @(posedge mclk) flipflop_clear <= 1'b1;
      @(posedge mclk) flipflop_clear <= 1'b0;
      repeat (4) @(posedge mclk);
      `CHK(flipflop_output_pin, 1'b0)
      t_diff();
      t_width();
      t_comp();
      t_freq();
      t_shot();
      end_of_test();
   end
endmodule
